// ==== design/cvs_scheduler.sv ====
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
// Summary of operation
// R1 - Mux serves cells, temps, pins, regulator, ground
// R2 - Cell reading is adjacent pin difference
// R3 - Corrected cell result is 16-bit millivolts
// R4 - Raw 24-bit count kept, 32-bit readout
// R5 - Every loop converts all ten cells
// R6 - One slot rotates stack, pack, load
// R7 - One slot rotates temperature, regulator, ground
// R8 - Up to three thermistor or input slots
// R9 - Full set completes every three loops
// R10 - Loop has 12 to 15 slots
// R11 - Slot lasts 3 ms or 1.5 ms
// R12 - Idle slots appended for slower loops
// R13 - Cell mask disables unused input protections
// R14 - Results reported for every cell input
// R15 - Host validates sleep readings against neighbours
// R16 - Host spaces sleep reads beyond interval
// R17 - Spurious reading never latches long-delay fault
// R18 - Undervoltage uses comparator, ignores spurious readings
module cvs_scheduler #(
  parameter int unsigned SLOT_CYC = cvs_pkg::SLOT_CYC,
  parameter int unsigned FAST_SLOT_CYC = cvs_pkg::FAST_SLOT_CYC,
  parameter int unsigned TICK_CYC = cvs_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [4:0] adc_channel,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [23:0] adc_raw,
  input wire logic [cvs_pkg::NUM_CELLS-1:0] cuv_cmp,
  output logic [cvs_pkg::NUM_CELLS-1:0] cell_prot_en,
  output logic irq
);
  import cvs_pkg::*;

  // Whole block state, registered as one word
  typedef struct packed {
    cvs_state_e st; // Sequencer state
    logic [19:0] cyc; // Cycles into current slot
    logic [3:0] slot; // Measurement slot index
    logic [7:0] idle_cnt; // Idle slots still to run
    logic [1:0] phase; // Loop number within a set of three
    logic got; // Result of this slot already taken
    logic [4:0] chan; // Channel driven to the converter
    logic start; // Conversion start pulse
    logic run; // Sequencer enable
    logic fast; // Short slot select
    logic [7:0] idle; // Idle slots per loop
    logic [9:0] cell_mask; // Inputs carrying real cells
    logic [8:0] therm_en; // Enabled thermistor or general inputs
    logic [23:0] offset; // Offset trim in counts
    logic [15:0] gain; // Gain, 8 fraction bits
    logic [15:0] suv_thr; // Safety undervoltage threshold, mV
    logic [15:0] suv_delay; // Safety undervoltage delay, ms
    logic cuv_en; // Comparator undervoltage enable
    logic [STAT_W-1:0] status; // Sticky event flags
    logic [STAT_W-1:0] irq_mask; // Interrupt enables
    logic [4:0] sel; // Result readout channel
    logic [NUM_CH-1:0][15:0] mv; // Corrected results
    logic [NUM_CH-1:0][23:0] raw; // Uncorrected counts
    logic [9:0] low; // Last reading per cell below threshold
    logic [17:0] tick_cyc; // Millisecond divider
    logic [15:0] low_ms; // Time the low condition has persisted
    logic [31:0] rdata; // Read data, one cycle after strobe
  } cvs_state_s;

  cvs_state_s s;
  cvs_state_s next_s;

  // Number of enabled thermistor or general inputs
  function automatic logic [3:0] popcnt(input logic [8:0] en);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < NUM_THERM; i++) begin
      c = c + {3'b000, en[i]};
    end
    return c;
  endfunction

  // Index of the last measurement slot of a loop
  function automatic logic [3:0] last_slot(input logic [8:0] en);
    logic [3:0] c;
    c = popcnt(en);
    if (c > 4'(THERM_SLOTS)) begin
      c = 4'(THERM_SLOTS);
    end
    return SLOT_THERM + c - 4'h1; // R10
  endfunction

  // Channel measured in a slot of a given loop phase
  function automatic logic [4:0] chan_for(input logic [3:0] sl, input logic [1:0] ph,
                                          input logic [8:0] en);
    logic [3:0] c;
    logic [3:0] j;
    logic [3:0] seen;
    logic [4:0] ch;
    c = popcnt(en);
    j = sl - SLOT_THERM;
    seen = 4'h0;
    ch = CH_THERM0;
    // More than three inputs: walk the enabled list three per loop, so three
    // loops cover all nine; fewer are all measured every loop
    if (c > 4'(THERM_SLOTS)) begin
      j = 4'((32'(ph) * THERM_SLOTS + 32'(j)) % 32'(c)); // R9
    end
    for (int i = 0; i < NUM_THERM; i++) begin
      if (en[i]) begin
        if (seen == j) begin
          ch = 5'(CH_THERM0 + 5'(i)); // R8
        end
        seen = seen + 4'h1;
      end
    end
    if (sl < SLOT_AUX) begin
      ch = {1'b0, sl}; // R2 R5
    end else if (sl == SLOT_AUX) begin
      ch = CH_TOP + {3'b000, ph}; // R6
    end else if (sl == SLOT_INT) begin
      ch = CH_TEMP + {3'b000, ph}; // R7 R1
    end
    return ch;
  endfunction

  logic [19:0] slot_end; // Last cycle of a slot
  logic [3:0] last_meas; // Last measurement slot this loop
  logic signed [24:0] diff; // Count after offset trim
  logic signed [41:0] prod; // Trimmed count times gain
  logic [15:0] mv_calc; // Millivolt result of current conversion
  logic suv_cond; // A real cell last read below threshold
  logic cuv_ev; // Comparator undervoltage on a real cell
  logic tick; // One millisecond enable
  logic wrap; // Loop ends this cycle
  logic take; // Result captured this cycle
  logic [STAT_W-1:0] set_ev; // Events raised this cycle
  logic [STAT_W-1:0] clr; // Write-one-to-clear bits

  // Trim and scale the raw count into millivolts
  always_comb begin
    diff = $signed({1'b0, adc_raw}) - $signed({1'b0, s.offset});
    prod = diff * $signed({1'b0, s.gain});
    mv_calc = prod[23:8]; // R3
  end

  // Protection conditions only look at inputs marked as cells
  assign suv_cond = |(s.low & s.cell_mask); // R13
  assign cuv_ev = s.cuv_en && |(cuv_cmp & s.cell_mask); // R13 R18
  assign slot_end = s.fast ? 20'(FAST_SLOT_CYC - 1) : 20'(SLOT_CYC - 1); // R11
  assign last_meas = last_slot(s.therm_en);
  assign tick = s.tick_cyc == 18'(TICK_CYC - 1);

  // Next-state logic: sequencer, capture, protections, register port
  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    next_s.rdata = 32'h0000_0000;
    wrap = 1'b0;
    take = 1'b0;
    set_ev = '0;
    clr = '0;
    next_s.tick_cyc = tick ? 18'h0_0000 : s.tick_cyc + 18'h0_0001;
    case (s.st)
      SEQ_STOP: begin
        // Wait for software to enable the loop
        if (s.run) begin
          next_s.st = SEQ_MEAS;
          next_s.slot = 4'h0;
          next_s.cyc = 20'h0_0000;
          next_s.got = 1'b0;
          next_s.start = 1'b1;
          next_s.chan = chan_for(4'h0, s.phase, s.therm_en);
        end
      end
      SEQ_MEAS: begin
        // Take the first result of the slot; late extra results are ignored
        if (adc_done && !s.got) begin
          take = 1'b1;
          next_s.got = 1'b1;
          next_s.raw[s.chan] = adc_raw; // R4 R14
          next_s.mv[s.chan] = mv_calc; // R14
          if (s.chan < 5'(NUM_CELLS)) begin
            next_s.low[s.chan[3:0]] = mv_calc < s.suv_thr;
          end
        end
        if (s.cyc != slot_end) begin
          next_s.cyc = s.cyc + 20'h0_0001;
        end else if (s.slot != last_meas) begin
          next_s.cyc = 20'h0_0000;
          next_s.slot = s.slot + 4'h1;
          next_s.got = 1'b0;
          next_s.start = 1'b1;
          next_s.chan = chan_for(s.slot + 4'h1, s.phase, s.therm_en);
        end else if (s.idle != 8'h00) begin
          // Slower loop: pad with idle slots after the measurements
          next_s.cyc = 20'h0_0000;
          next_s.st = SEQ_REST; // R12
          next_s.idle_cnt = s.idle - 8'h01;
        end else begin
          wrap = 1'b1;
        end
      end
      SEQ_REST: begin
        // Idle slot: converter left alone, same slot length
        if (s.cyc != slot_end) begin
          next_s.cyc = s.cyc + 20'h0_0001;
        end else if (s.idle_cnt != 8'h00) begin
          next_s.cyc = 20'h0_0000;
          next_s.idle_cnt = s.idle_cnt - 8'h01; // R12
        end else begin
          wrap = 1'b1;
        end
      end
      default: begin
        next_s.st = SEQ_STOP;
      end
    endcase
    // Loop end: advance the rotation, stop here if disabled
    if (wrap) begin
      set_ev[STAT_LOOP] = 1'b1;
      if (s.phase == 2'(LOOP_SET - 1)) begin
        next_s.phase = 2'b00;
        set_ev[STAT_SET] = 1'b1; // R9
      end else begin
        next_s.phase = s.phase + 2'b01;
      end
      next_s.cyc = 20'h0_0000;
      next_s.slot = 4'h0;
      next_s.got = 1'b0;
      if (s.run) begin
        next_s.st = SEQ_MEAS;
        next_s.start = 1'b1;
        next_s.chan = chan_for(4'h0, next_s.phase, s.therm_en);
      end else begin
        next_s.st = SEQ_STOP;
      end
    end
    // A single low reading raises the alert; the fault needs it to persist
    // for the delay, so a spurious reading is cleared by the next good one
    if (!suv_cond) begin
      next_s.low_ms = 16'h0000;
    end else if (tick && s.low_ms != 16'hffff) begin
      next_s.low_ms = s.low_ms + 16'h0001;
    end
    set_ev[STAT_SUV_ALERT] = suv_cond; // R17
    set_ev[STAT_SUV_FAULT] = suv_cond && s.low_ms >= s.suv_delay; // R17
    set_ev[STAT_CUV] = cuv_ev; // R18
    // Register writes
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        next_s.run = reg_wdata[CTRL_RUN];
        next_s.fast = reg_wdata[CTRL_FAST]; // R11
        next_s.idle = reg_wdata[CTRL_IDLE_LSB +: 8];
      end else if (reg_addr == REG_CELL_MASK) begin
        next_s.cell_mask = reg_wdata[9:0];
      end else if (reg_addr == REG_THERM_EN) begin
        next_s.therm_en = reg_wdata[8:0];
      end else if (reg_addr == REG_OFFSET) begin
        next_s.offset = reg_wdata[23:0];
      end else if (reg_addr == REG_GAIN) begin
        next_s.gain = reg_wdata[15:0];
      end else if (reg_addr == REG_SUV_THR) begin
        next_s.suv_thr = reg_wdata[15:0];
      end else if (reg_addr == REG_SUV_DELAY) begin
        next_s.suv_delay = reg_wdata[15:0];
      end else if (reg_addr == REG_CUV_EN) begin
        next_s.cuv_en = reg_wdata[0];
      end else if (reg_addr == REG_STATUS) begin
        clr = reg_wdata[STAT_W-1:0];
      end else if (reg_addr == REG_IRQ_MASK) begin
        next_s.irq_mask = reg_wdata[STAT_W-1:0];
      end else if (reg_addr == REG_SEL) begin
        next_s.sel = reg_wdata[4:0];
      end
    end
    // Set wins over a clear in the same cycle
    next_s.status = (s.status & ~clr) | set_ev;
    // Register reads; unmapped offsets and out-of-range channels read zero
    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        next_s.rdata = {16'h0000, s.idle, 6'h00, s.fast, s.run};
      end else if (reg_addr == REG_CELL_MASK) begin
        next_s.rdata = {22'h00_0000, s.cell_mask};
      end else if (reg_addr == REG_THERM_EN) begin
        next_s.rdata = {23'h00_0000, s.therm_en};
      end else if (reg_addr == REG_OFFSET) begin
        next_s.rdata = {8'h00, s.offset};
      end else if (reg_addr == REG_GAIN) begin
        next_s.rdata = {16'h0000, s.gain};
      end else if (reg_addr == REG_SUV_THR) begin
        next_s.rdata = {16'h0000, s.suv_thr};
      end else if (reg_addr == REG_SUV_DELAY) begin
        next_s.rdata = {16'h0000, s.suv_delay};
      end else if (reg_addr == REG_CUV_EN) begin
        next_s.rdata = {31'h0000_0000, s.cuv_en};
      end else if (reg_addr == REG_STATUS) begin
        next_s.rdata = {27'h000_0000, s.status};
      end else if (reg_addr == REG_IRQ_MASK) begin
        next_s.rdata = {27'h000_0000, s.irq_mask};
      end else if (reg_addr == REG_SEL) begin
        next_s.rdata = {27'h000_0000, s.sel};
      end else if (reg_addr == REG_MV && s.sel < 5'(NUM_CH)) begin
        next_s.rdata = {16'h0000, s.mv[s.sel]}; // R14
      end else if (reg_addr == REG_RAW && s.sel < 5'(NUM_CH)) begin
        next_s.rdata = {{8{s.raw[s.sel][23]}}, s.raw[s.sel]}; // R4
      end else if (reg_addr == REG_LOOP) begin
        next_s.rdata = {16'h0000, last_meas + 4'h1, 2'b00, s.phase, 6'h00, s.st};
      end
    end
  end

  // State register with reset values
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.st <= SEQ_STOP;
      s.cell_mask <= CELL_MASK_RST;
      s.gain <= GAIN_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign reg_rdata = s.rdata;
  assign adc_channel = s.chan;
  assign adc_start = s.start;
  assign cell_prot_en = s.cell_mask; // R13
  assign irq = |(s.status & s.irq_mask);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Slot boundaries seen by the converter
  sequence slot_begin;
    s.start && s.st == SEQ_MEAS;
  endsequence
  sequence cell_begin;
    slot_begin ##0 s.slot < SLOT_AUX;
  endsequence

  cell_chan_a: assert property (cell_begin |-> s.chan == {1'b0, s.slot}) // R5
    else $error("cell slot drove wrong channel");
  aux_rot_a: assert property (slot_begin ##0 s.slot == SLOT_AUX |->
                              s.chan == CH_TOP + {3'b000, s.phase}) // R6
    else $error("auxiliary pin slot out of rotation");
  int_rot_a: assert property (slot_begin ##0 s.slot == SLOT_INT |->
                              s.chan == CH_TEMP + {3'b000, s.phase}) // R7
    else $error("internal slot out of rotation");
  therm_slot_a: assert property (slot_begin ##0 s.slot >= SLOT_THERM |->
                                 s.chan >= CH_THERM0 && s.therm_en != 9'h000) // R8
    else $error("thermistor slot without enabled input");
  loop_len_a: assert property (wrap && s.st == SEQ_MEAS |-> s.slot == last_meas) // R10
    else $error("loop ended at wrong slot count");
  set_done_a: assert property ($rose(s.status[STAT_SET]) |-> $past(s.phase) == 2'b10) // R9
    else $error("set completion outside third loop");
  slot_gap_a: assert property (slot_begin |=> !s.start [*8]) // R11
    else $error("slot shorter than its length");
  idle_quiet_a: assert property (s.st == SEQ_REST |-> !s.start ##1 !take) // R12
    else $error("conversion during idle slot");
  raw_keep_a: assert property (take |=> s.raw[$past(s.chan)] == $past(adc_raw)) // R4
    else $error("raw count not stored");
  mv_keep_a: assert property (take |=> s.mv[$past(s.chan)] == $past(mv_calc)) // R3
    else $error("millivolt result not stored");
  cuv_src_a: assert property (!s.cuv_en [*2] |-> !$rose(s.status[STAT_CUV])) // R18
    else $error("undervoltage flag without enable");
  suv_fault_a: assert property ($rose(s.status[STAT_SUV_FAULT]) |->
                                $past(suv_cond) && $past(s.low_ms) >= $past(s.suv_delay)) // R17
    else $error("safety fault latched without persistence");
  prot_mask_a: assert property (cell_prot_en == s.cell_mask) // R13
    else $error("protection enable differs from cell mask");
endmodule

// ==== design/cvs_pkg.sv ====
package cvs_pkg;
  // Core clock and slot timing, times in microseconds
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SLOT_US = 3000;
  localparam int unsigned FAST_SLOT_US = 1500;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned SLOT_CYC = SLOT_US * CLK_MHZ;
  localparam int unsigned FAST_SLOT_CYC = FAST_SLOT_US * CLK_MHZ;
  localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
  // Loop structure
  localparam int NUM_CELLS = 10;
  localparam int NUM_THERM = 9;
  localparam int NUM_CH = 25;
  localparam int THERM_SLOTS = 3;
  localparam int LOOP_SET = 3;
  localparam logic [3:0] SLOT_AUX = 4'h0a;
  localparam logic [3:0] SLOT_INT = 4'h0b;
  localparam logic [3:0] SLOT_THERM = 4'h0c;
  // Converter channel codes
  localparam logic [4:0] CH_TOP = 5'h0a;
  localparam logic [4:0] CH_PACK = 5'h0b;
  localparam logic [4:0] CH_LOAD = 5'h0c;
  localparam logic [4:0] CH_TEMP = 5'h0d;
  localparam logic [4:0] CH_INTERNAL_1V8_REGULATOR = 5'h0e;
  localparam logic [4:0] CH_GND = 5'h0f;
  localparam logic [4:0] CH_THERM0 = 5'h10;
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CELL_MASK = 8'h04;
  localparam logic [7:0] REG_THERM_EN = 8'h08;
  localparam logic [7:0] REG_OFFSET = 8'h0c;
  localparam logic [7:0] REG_GAIN = 8'h10;
  localparam logic [7:0] REG_SUV_THR = 8'h14;
  localparam logic [7:0] REG_SUV_DELAY = 8'h18;
  localparam logic [7:0] REG_CUV_EN = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK = 8'h24;
  localparam logic [7:0] REG_SEL = 8'h28;
  localparam logic [7:0] REG_MV = 8'h2c;
  localparam logic [7:0] REG_RAW = 8'h30;
  localparam logic [7:0] REG_LOOP = 8'h34;
  // Field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_FAST = 1;
  localparam int CTRL_IDLE_LSB = 8;
  localparam int STAT_LOOP = 0;
  localparam int STAT_SET = 1;
  localparam int STAT_SUV_ALERT = 2;
  localparam int STAT_SUV_FAULT = 3;
  localparam int STAT_CUV = 4;
  localparam int STAT_W = 5;
  // Reset values
  localparam logic [9:0] CELL_MASK_RST = 10'h3ff;
  localparam logic [15:0] GAIN_RST = 16'h0100;
  // Sequencer states
  typedef enum logic [1:0] {SEQ_STOP, SEQ_MEAS, SEQ_REST} cvs_state_e;
endpackage

// ==== verification/cvs_cell_stack_model.sv ====
`timescale 1ns/100ps
module cvs_cell_stack_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic adc_start,
  input wire logic [4:0] adc_channel,
  input wire logic [23:0] base,
  input wire logic [2:0] dly,
  input wire logic dbl,
  input wire logic [9:0] cuv_set,
  output logic adc_done,
  output logic [23:0] adc_raw,
  output logic [9:0] cuv_cmp
);
  logic [3:0] cnt; // Cycles since slot start, parks at 15
  logic [23:0] last; // Last good sample handed over

  // Each channel code gives its own count, so a wrong mux choice shows up
  // Outside the answer cycle the raw bus carries the inverse, never a stale value
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 4'hf;
      adc_done <= 1'b0;
      adc_raw <= 24'h5a_5a5a;
      last <= 24'h00_0000;
    end else begin
      cnt <= adc_start ? 4'h0 : ((cnt == 4'hf) ? cnt : cnt + 4'h1);
      adc_done <= 1'b0;
      adc_raw <= ~last;
      if (cnt == {1'b0, dly}) begin
        adc_done <= 1'b1;
        adc_raw <= base + {19'h0_0000, adc_channel};
        last <= base + {19'h0_0000, adc_channel};
      end else if (dbl && cnt == {1'b0, dly} + 4'h2) begin
        // Commanded fault: a second, corrupt answer in the same slot
        adc_done <= 1'b1;
        adc_raw <= ~last;
      end
    end
  end

  // Comparator path is separate from the sampled result
  assign cuv_cmp = cuv_set;
endmodule

// ==== verification/test_cell_voltage_measurement_scheduler.sv ====
`timescale 1ns/100ps
module test_cell_voltage_measurement_scheduler;
  import cvs_pkg::*;
  localparam int S_SLOT = 20; // Shortened slot
  localparam int S_FAST = 10; // Shortened fast slot
  localparam int LIMIT = 50000; // Hang ceiling in cycles
  logic clk;
  logic rst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [4:0] adc_channel;
  logic adc_start;
  logic adc_done;
  logic [23:0] adc_raw;
  logic [9:0] cuv_cmp;
  logic [9:0] cell_prot_en;
  logic irq;
  logic [23:0] base; // Partner reading base
  logic [2:0] dly; // Partner answer delay
  logic dbl; // Partner double answer
  logic [9:0] cuv_set; // Partner comparator levels
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  logic [15:0] lf = 16'h0041; // Random source state
  logic [4:0] q_ch[$]; // Channels seen at slot starts
  int q_cyc[$]; // Cycle of each slot start
  logic [8:0] ens[6] = '{9'h000, 9'h004, 9'h081, 9'h111, 9'h0f5, 9'h1ff};

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  cvs_scheduler #(.SLOT_CYC(S_SLOT), .FAST_SLOT_CYC(S_FAST), .TICK_CYC(16)) u_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_channel(adc_channel),
    .adc_start(adc_start), .adc_done(adc_done), .adc_raw(adc_raw), .cuv_cmp(cuv_cmp),
    .cell_prot_en(cell_prot_en), .irq(irq));

  cvs_cell_stack_model u_stack (
    .clk(clk), .rst(rst), .adc_start(adc_start), .adc_channel(adc_channel), .base(base),
    .dly(dly), .dbl(dbl), .cuv_set(cuv_set), .adc_done(adc_done), .adc_raw(adc_raw),
    .cuv_cmp(cuv_cmp));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Slot monitor and hang guard; a pulse is sampled in the cycle it stands
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (adc_start === 1'b1) begin
      q_ch.push_back(adc_channel);
      q_cyc.push_back(cyc);
    end
    if (cyc == LIMIT) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Bus write; returns once the write has landed
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Bus read; data is taken in the one cycle it stands
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  // Corrected result: only product bits 23:8 matter, so sign handling cannot differ
  function automatic logic [15:0] exp_mv(logic [23:0] raw, logic [23:0] off, logic [15:0] g);
    logic [47:0] p;
    p = {24'h00_0000, raw - off} * {32'h0000_0000, g};
    return p[23:8];
  endfunction

  // Channel expected in slot k of loop l
  function automatic logic [4:0] exp_ch(logic [8:0] en, int k, int l);
    int lst[9];
    int n;
    n = 0;
    for (int b = 0; b < 9; b++) begin
      if (en[b]) begin
        lst[n] = b;
        n++;
      end
    end
    if (k < 10) return 5'(k);
    if (k == 10) return CH_TOP + 5'(l);
    if (k == 11) return CH_TEMP + 5'(l);
    return CH_THERM0 + 5'((n <= 3) ? lst[k - 12] : lst[(l * 3 + k - 12) % n]);
  endfunction

  initial begin
    logic [31:0] d;
    logic [23:0] off;
    logic [15:0] g;
    logic [9:0] mask;
    logic [8:0] en;
    logic [4:0] st;
    logic al;
    logic [9:0] lv; // Expected low-reading flags left by the last run
    logic [23:0] er; // Expected raw count of one channel
    int n, ns, s, idle, fast, thr;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    base = 24'h00_0000;
    dly = 3'h1;
    dbl = 1'b0;
    cuv_set = 10'h000;
    lv = 10'h000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(REG_CELL_MASK, d);
    chk(d, 32'h0000_03ff, "mask reset");
    rd(REG_THERM_EN, d);
    chk(d, 32'h0000_0000, "therm reset");
    rd(REG_GAIN, d);
    chk(d, 32'h0000_0100, "gain reset");
    rd(8'h3c, d);
    chk(d, 32'h0000_0000, "unmapped read");
    chk({irq, adc_start, cell_prot_en}, 12'h3ff, "outputs at reset");
    for (int i = 0; i < 6; i++) begin
      en = ens[i];
      n = $countones(en);
      ns = 12 + ((n < 3) ? n : 3);
      fast = i % 2;
      idle = i % 3;
      s = fast ? S_FAST : S_SLOT;
      thr = fast ? 32'h0000_ffff : 0;
      mask = 10'(rnd()) | 10'h007;
      off = {8'h00, rnd()};
      g = rnd();
      base <= 24'({rnd(), rnd()});
      dly <= 3'(rnd() % 4) + 3'h1;
      dbl <= lf[3];
      cuv_set <= 10'(rnd());
      wr(REG_SUV_THR, 0);
      wr(REG_CELL_MASK, mask);
      wr(REG_THERM_EN, en);
      wr(REG_OFFSET, off);
      wr(REG_GAIN, g);
      wr(REG_SUV_DELAY, (i == 5) ? 1 : 1000);
      // Third scenario runs with the comparator path disabled
      wr(REG_CUV_EN, 32'(i != 2));
      wr(REG_STATUS, 32'h0000_001f);
      wr(REG_SUV_THR, thr);
      chk(cell_prot_en, mask, "protection enables");
      q_ch.delete();
      q_cyc.delete();
      wr(REG_CTRL, (idle << CTRL_IDLE_LSB) | (fast << CTRL_FAST) | 1);
      for (int w = 0; w < 4000 && q_ch.size() < 3 * ns; w++) @(posedge clk);
      wr(REG_CTRL, 0);
      repeat ((idle + 3) * s) @(posedge clk);
      chk(q_ch.size(), 3 * ns, "slots in three loops");
      for (int j = 0; j < 3 * ns; j++) begin
        chk(q_ch[j], exp_ch(en, j % ns, j / ns), "slot channel");
        if (j > 0) chk(q_cyc[j] - q_cyc[j - 1], (j % ns == 0) ? (idle + 1) * s : s, "gap");
      end
      rd(REG_LOOP, d);
      chk({d[15:12], d[9:8], d[1:0]}, {4'(ns), 2'h0, 2'h0}, "loop, phase, stop");
      // Readings kept from the last run hold the alert through the clear
      al = |(lv & mask);
      lv = 10'h000;
      for (int c = 0; c < 10; c++) begin
        if (thr != 0 && exp_mv(base + 24'(c), off, g) < 16'hffff) lv[c] = 1'b1;
      end
      st = {|(cuv_set & mask) && (i != 2), |(lv & mask) && (i == 5), al || |(lv & mask), 2'b11};
      rd(REG_STATUS, d);
      chk(d, {27'h0, st}, "status after run");
      wr(REG_IRQ_MASK, 32'h0000_0001);
      chk(irq, 1'b1, "irq raised");
      wr(REG_IRQ_MASK, 32'h0000_0000);
      chk(irq, 1'b0, "irq masked");
      wr(REG_IRQ_MASK, 32'h0000_0003);
      wr(REG_STATUS, 32'h0000_0003);
      chk(irq, 1'b0, "irq cleared");
      rd(REG_STATUS, d);
      chk(d, {27'h0, st & 5'h1c}, "status clear by one");
      // Read back raw and millivolt results of every channel converted in the run
      for (int c = 0; c < 25; c++) begin
        if (c < 16 || en[c - 16]) begin
          wr(REG_SEL, c);
          er = base + 24'(c);
          rd(REG_RAW, d);
          chk(d, {{8{er[23]}}, er}, "raw result");
          rd(REG_MV, d);
          chk(d, {16'h0000, exp_mv(er, off, g)}, "mv");
        end
      end
      wr(REG_SEL, 25);
      rd(REG_MV, d);
      chk(d, 32'h0000_0000, "result beyond channels");
    end
    end_of_test();
  end
endmodule
